// ===== hdl/isvm_top.sv
// Interrupt source to vector map for requests 39..63.
// Assumes synchronous events and a core that acknowledges a vector.
//
// Overview of operation
// R1: First UART fault, receive and transmit raise 39..41 on vector 32.
// R2: First I2C collision, target, controller raise 42..44 on vector 33.
// R3: Port A, B, C change raise 45..47 on vector 34.
// R4: Parallel port done and error raise 48 and 49 on vector 35.
// R5: Second SPI fault, receive, transmit raise 50..52 on vector 36.
// R6: Second UART error, receive, transmit raise 53..55 on vector 37.
// R7: Second I2C collision, target, controller raise 56..58 on vector 38.
// R8: Each DMA channel raises 60..63 on its own vector 40..43.
// R9: DMA requests are non-persistent, all others persistent.
// R10: An absent peripheral never asserts its request.
// R11: A request needs flag and enable; a vector takes its group priority.
`timescale 1ns/10ps
module isvm_top
  import isvm_pkg::*;
#(
  parameter logic [isvm_pkg::SRC_CNT-1:0] PRESENT = isvm_pkg::SRC_PRESENT_DEF
) (
  input  wire logic                       clk,          // System clock
  input  wire logic                       rst,          // Sync reset, high
  input  wire logic [isvm_pkg::SRC_CNT-1:0] srcEvent,   // Events, bit 0 = 39
  input  wire logic [isvm_pkg::REG_W-1:0] enableReg,    // Enable word
  input  wire logic [isvm_pkg::REG_W-1:0] priorityReg8, // Priority word 8
  input  wire logic [isvm_pkg::REG_W-1:0] priorityReg9, // Priority word 9
  input  wire logic [isvm_pkg::REG_W-1:0] priorityReg10,// Priority word 10
  input  wire logic                       irqAck,       // Core takes request
  output logic [isvm_pkg::REG_W-1:0]      flagReg,      // Flag word
  output logic                            irqValid,     // Request to core
  output logic [isvm_pkg::IRQ_W-1:0]      irqNum,       // Request number
  output logic [isvm_pkg::VEC_W-1:0]      irqVector,    // Vector number
  output logic [isvm_pkg::PRI_W-1:0]      irqPriority,  // Group priority
  output logic [isvm_pkg::SUB_W-1:0]      irqSubPri     // Group sub-priority
);
  import isvm_pkg::*;

  // ------------------------------------------------------------
  // Per-source flags
  // ------------------------------------------------------------
  logic [SRC_CNT-1:0] flags;
  logic [SRC_CNT-1:0] reqs;
  logic [SRC_CNT-1:0] clrOne;

  // R1: R2: R3: R4: R5: R6: R7: R8: one flag per source on bits 7..31
  // R9: persistence set per source
  for (genvar i = 0; i < SRC_CNT; i++) begin : g_src
    isvm_src_flag #(
      .PERSIST (SRC_PERSIST[i]),
      .PRESENT (PRESENT[i])
    ) u_flag (
      .clk     (clk),
      .rst     (rst),
      .event_i (srcEvent[i]),
      .enable  (enableReg[FLAG_BASE+i]),
      .flagClr (clrOne[i]),
      .flag    (flags[i]),
      .request (reqs[i])
    );
  end

  // ------------------------------------------------------------
  // Selection
  // ------------------------------------------------------------
  logic [REG_W-1:0] preg [3];
  assign preg[0] = priorityReg8;
  assign preg[1] = priorityReg9;
  assign preg[2] = priorityReg10;

  // Highest priority, then sub-priority, wins; ties go to the lower request number
  // (natural order), which the strict compare keeps.
  logic               anyReq;
  logic [4:0]         selIdx;
  logic [PRI_W-1:0]   selPri;
  logic [SUB_W-1:0]   selSub;

  always_comb begin
    logic [PRI_W-1:0] p;
    logic [SUB_W-1:0] s;
    int unsigned      g;
    p      = '0;
    s      = '0;
    g      = 0;
    anyReq = 1'b0;
    selIdx = '0;
    selPri = '0;
    selSub = '0;
    for (int i = 0; i < SRC_CNT; i++) begin
      g = SRC_GRP[i];
      // R11: group shares one priority field
      p = preg[GRP_PREG[g]][GRP_LANE[g]+PRI_OFS +: PRI_W];
      s = preg[GRP_PREG[g]][GRP_LANE[g] +: SUB_W];
      // Priority zero means disabled at the core
      if (reqs[i] && (p != '0) && (!anyReq || {p, s} > {selPri, selSub}))
      begin
        anyReq = 1'b1;
        selIdx = 5'(i);
        selPri = p;
        selSub = s;
      end
    end
  end

  // ------------------------------------------------------------
  // Hand-off to the core
  // ------------------------------------------------------------
  isvm_state_t      state_q, state_d;
  logic [4:0]       idx_q, idx_d;
  logic             valid_d;
  logic [IRQ_W-1:0] num_d;
  logic [VEC_W-1:0] vec_d;
  logic [PRI_W-1:0] pri_d;
  logic [SUB_W-1:0] sub_d;

  always_comb begin
    state_d = state_q;
    idx_d   = idx_q;
    clrOne  = '0;
    unique case (state_q)
      ISVM_IDLE: begin
        if (anyReq) begin
          state_d = ISVM_REQ;
          idx_d   = selIdx;
        end
      end
      ISVM_REQ: begin
        if (irqAck) begin
          clrOne[idx_q] = 1'b1;
          state_d       = ISVM_IDLE;
        end else if (!reqs[idx_q]) begin
          // Source disabled meanwhile: withdraw
          state_d = ISVM_IDLE;
        end
      end
      default: state_d = ISVM_IDLE;
    endcase
    valid_d = (state_d == ISVM_REQ);
    num_d   = IRQ_W'(IRQ_BASE) + IRQ_W'(idx_d);
    vec_d   = GRP_VEC[SRC_GRP[idx_d]];
    pri_d   = preg[GRP_PREG[SRC_GRP[idx_d]]]
                  [GRP_LANE[SRC_GRP[idx_d]]+PRI_OFS +: PRI_W];
    sub_d   = preg[GRP_PREG[SRC_GRP[idx_d]]]
                  [GRP_LANE[SRC_GRP[idx_d]] +: SUB_W];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q     <= ISVM_IDLE;
      idx_q       <= '0;
      irqValid    <= 1'b0;
      irqNum      <= '0;
      irqVector   <= '0;
      irqPriority <= '0;
      irqSubPri   <= '0;
      flagReg     <= '0;
    end else begin
      state_q     <= state_d;
      idx_q       <= idx_d;
      irqValid    <= valid_d;
      irqNum      <= num_d;
      irqVector   <= vec_d;
      irqPriority <= pri_d;
      irqSubPri   <= sub_d;
      flagReg     <= {flags, {FLAG_BASE{1'b0}}};
    end
  end
endmodule

// ===== hdl/isvm_pkg.sv
// Package for the interrupt source to vector map.
// Assumes a single synchronous clock domain and a core that takes one vector.
package isvm_pkg;

  // ------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------
  localparam int unsigned SRC_CNT  = 25;  // Requests 39..63, 59 reserved
  localparam int unsigned GRP_CNT  = 11;  // Vectors 32..38, 40..43
  localparam int unsigned REG_W    = 32;
  localparam int unsigned PRI_W    = 3;
  localparam int unsigned SUB_W    = 2;
  localparam int unsigned IRQ_W    = 6;
  localparam int unsigned VEC_W    = 6;

  // ------------------------------------------------------------
  // Map: flag/enable bit of first source, request, vector
  // ------------------------------------------------------------
  localparam int unsigned FLAG_BASE = 7;   // Source 0 sits on bit 7
  localparam int unsigned IRQ_BASE  = 39;  // Source 0 is request 39

  // Group of each source (index 0 = bit 7); one group per DMA channel
  localparam logic [3:0] SRC_GRP [SRC_CNT] = '{
    4'h0, 4'h0, 4'h0, 4'h1, 4'h1, 4'h1, 4'h2, 4'h2, 4'h2,
    4'h3, 4'h3, 4'h4, 4'h4, 4'h4, 4'h5, 4'h5, 4'h5,
    4'h6, 4'h6, 4'h6, 4'h7, 4'h7, 4'h8, 4'h9, 4'hA};

  localparam logic [VEC_W-1:0] GRP_VEC [GRP_CNT] = '{
    6'h20, 6'h21, 6'h22, 6'h23, 6'h24, 6'h25, 6'h26,
    6'h28, 6'h29, 6'h2A, 6'h2B};

  // Priority field low bit within its register (sub at +0, pri at +2)
  localparam int unsigned GRP_LANE [GRP_CNT] = '{
    0, 8, 16, 24, 0, 8, 16, 0, 8, 16, 24};
  // Which priority register: 0 = eight, 1 = nine, 2 = ten
  localparam int unsigned GRP_PREG [GRP_CNT] = '{
    0, 0, 0, 0, 1, 1, 1, 2, 2, 2, 2};
  localparam int unsigned PRI_OFS = 2;

  // Persistent sources (everything but DMA on indices 21..24)
  localparam logic [SRC_CNT-1:0] SRC_PERSIST = 25'h01F_FFFF;
  // Peripheral presence per variant; index 20 (request 59) has no
  // source in this range, so it stays absent; it shares group 7 with request 60
  localparam logic [SRC_CNT-1:0] SRC_PRESENT_DEF = 25'h1EF_FFFF;

  typedef enum logic [1:0] {
    ISVM_IDLE = 2'b00,
    ISVM_REQ  = 2'b01
  } isvm_state_t;

endpackage

// ===== hdl/isvm_src_flag.sv
// One source's flag: event capture, persistence and request gating.
// Assumes events are synchronous one-cycle or level pulses.
`timescale 1ns/10ps
module isvm_src_flag #(
  parameter bit PERSIST = 1'b1,
  parameter bit PRESENT = 1'b1
) (
  input  wire logic clk,        // System clock
  input  wire logic rst,        // Sync reset, high
  input  wire logic event_i,    // Peripheral event
  input  wire logic enable,     // Enable bit
  input  wire logic flagClr,    // Clear from vector dispatch
  output logic      flag,       // Flag bit
  output logic      request     // Gated request
);
  logic flag_q;
  logic flag_d;
  logic evtLast_q;
  logic evtLast_d;
  logic setHit;

  always_comb begin
    evtLast_d = event_i;
    // R9: persistent source re-arms while its level stands; a pulse
    // source needs a fresh rising edge, so a held line fires only once
    setHit = PERSIST ? event_i : (event_i & ~evtLast_q);
    flag_d = flag_q;
    if (flagClr) begin
      flag_d = 1'b0;
    end
    // Set wins over clear
    if (setHit) begin
      flag_d = 1'b1;
    end
    // R10: absent peripheral stays quiet
    if (!PRESENT) begin
      flag_d = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    // Edge memory resets to the idle level: a line held high across reset counts as an edge
    if (rst) begin
      flag_q    <= 1'b0;
      evtLast_q <= 1'b0;
    end else begin
      flag_q    <= flag_d;
      evtLast_q <= evtLast_d;
    end
  end

  assign flag = flag_q;
  // R11: flag and enable both
  assign request = flag_q & enable;
endmodule

// ===== verif/isvm_top_properties.sv
// Checker for the vector map outputs.
// Assumes it is bound to isvm_top and the priority words stay steady.
`timescale 1ns/10ps
module isvm_top_properties
  import isvm_pkg::*;
(
  input wire logic                         clk,           // Clock
  input wire logic                         rst,           // Reset
  input wire logic [isvm_pkg::REG_W-1:0]   enableReg,     // Enables
  input wire logic [isvm_pkg::REG_W-1:0]   priorityReg8,  // Pri 8
  input wire logic [isvm_pkg::REG_W-1:0]   priorityReg9,  // Pri 9
  input wire logic [isvm_pkg::REG_W-1:0]   priorityReg10, // Pri 10
  input wire logic [isvm_pkg::REG_W-1:0]   flagReg,       // Flags
  input wire logic                         irqValid,      // Request
  input wire logic [isvm_pkg::IRQ_W-1:0]   irqNum,        // Number
  input wire logic [isvm_pkg::VEC_W-1:0]   irqVector,     // Vector
  input wire logic [isvm_pkg::PRI_W-1:0]   irqPriority,   // Priority
  input wire logic [isvm_pkg::SUB_W-1:0]   irqSubPri      // Sub
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [95:0] prio;
  int          k;
  assign prio = {priorityReg10, priorityReg9, priorityReg8};
  // Field lane of the request shown; lane k also gives vector 32+k
  always_comb begin
    if (irqNum >= 6'd60) k = int'(irqNum) - 52;
    else if (irqNum >= 6'd50) k = 4 + (int'(irqNum) - 50) / 3;
    else if (irqNum >= 6'd48) k = 3;
    else if (irqNum >= 6'd39) k = (int'(irqNum) - 39) / 3;
    else k = 0;
  end
  a_flag_low_zero: assert property (
    flagReg[6:0] == 7'h00) else $error("low flag bits set");
  a_num_in_range: assert property (
    irqValid |-> irqNum inside {[6'd39:6'd58], [6'd60:6'd63]})
    else $error("request number out of range");
  a_absent_quiet: assert property (
    flagReg[27] == 1'b0) else $error("absent source flagged");
  a_vec_of_group: assert property (
    irqValid |-> irqVector == 6'd32 + k[5:0]) else $error("wrong vector");
  a_dma_own_vec: assert property (
    irqValid && irqNum >= 6'd60 |-> irqVector == irqNum - 6'd20)
    else $error("wrong channel vector");
  a_pri_of_group: assert property (
    irqValid |-> irqPriority == prio[8*k+2 +: 3]) else $error("bad pri");
  a_sub_of_group: assert property (
    irqValid |-> irqSubPri == prio[8*k +: 2]) else $error("bad sub");
  a_needs_enable: assert property (
    irqValid |-> enableReg[irqNum - 6'd32]) else $error("disabled shown");
  a_pri_not_zero: assert property (
    irqValid |-> irqPriority != 3'h0) else $error("zero priority shown");
endmodule
bind isvm_top isvm_top_properties i_isvm_top_properties (.*);

// ===== verif/isvm_core_model.sv
// Core dispatch model: takes a standing request after a wait.
// Assumes the map holds irqValid until it sees irqAck.
`timescale 1ns/10ps
module isvm_core_model #(
  parameter int ACK_WAIT = 2
) (
  input  wire logic clk,      // Clock
  input  wire logic rst,      // Reset
  input  wire logic irqValid, // Request shown
  output logic      irqAck    // One-cycle take
);
  int cnt;
  // Ack only while a request stands, never two cycles running
  always @(posedge clk) begin
    if (rst || !irqValid || irqAck) begin
      cnt <= 0;
      irqAck <= 1'b0;
    end else begin
      cnt <= cnt + 1;
      irqAck <= (cnt == ACK_WAIT - 1);
    end
  end
endmodule

// ===== verif/isvm_top_test.sv
// Bench for the vector map: every source, masking, persistence.
// Assumes the core model acks; every source but request 59 is present.
`timescale 1ns/10ps
module isvm_top_test;
  import isvm_pkg::*;
  logic                 clk, rst, irqAck, irqValid;
  logic [SRC_CNT-1:0]   srcEvent;
  logic [REG_W-1:0]     enableReg, priorityReg8, priorityReg9;
  logic [REG_W-1:0]     priorityReg10, flagReg;
  logic [IRQ_W-1:0]     irqNum;
  logic [VEC_W-1:0]     irqVector;
  logic [PRI_W-1:0]     irqPriority;
  logic [SUB_W-1:0]     irqSubPri;
  logic [95:0]          prio;
  int                   error_cnt = 0;
  int                   tests_run = 0;
  isvm_top i_isvm_top (
    .clk           (clk),
    .rst           (rst),
    .srcEvent      (srcEvent),
    .enableReg     (enableReg),
    .priorityReg8  (priorityReg8),
    .priorityReg9  (priorityReg9),
    .priorityReg10 (priorityReg10),
    .irqAck        (irqAck),
    .flagReg       (flagReg),
    .irqValid      (irqValid),
    .irqNum        (irqNum),
    .irqVector     (irqVector),
    .irqPriority   (irqPriority),
    .irqSubPri     (irqSubPri)
  );
  isvm_core_model #(.ACK_WAIT(2)) i_isvm_core_model (.clk(clk), .rst(rst),
    .irqValid(irqValid), .irqAck(irqAck));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %s exp %0h got %0h", name, exp, got);
    end
  endtask
  task automatic wait_hi(ref logic s, output bit ok);
    ok = 0;
    for (int n = 0; n < 12 && !ok; n++) begin
      @(posedge clk);
      #1;
      ok = (s === 1'b1);
    end
  endtask
  task automatic settle();
    int low;
    low = 0;
    for (int n = 0; n < 60 && low < 4; n++) begin
      @(posedge clk);
      #1;
      low = (irqValid === 1'b0) ? low + 1 : 0;
    end
    chk("settled", 4, low);
  endtask
  function automatic int lane(int num);
    if (num >= 60) return num - 52;
    if (num >= 50) return 4 + (num - 50) / 3;
    if (num >= 48) return 3;
    return (num - 39) / 3;
  endfunction
  task automatic t_map(int num);
    int i, k;
    bit ok;
    i = num - 39;
    k = lane(num);
    @(posedge clk);
    enableReg <= 32'h1 << (7 + i);
    srcEvent[i] <= 1'b1;
    @(posedge clk);
    srcEvent[i] <= 1'b0;
    wait_hi(irqValid, ok);
    chk("valid", 1, ok);
    chk("num", num, irqNum);
    chk("vector", 32 + k, irqVector);
    chk("pri", prio[8*k+2 +: 3], irqPriority);
    chk("sub", prio[8*k +: 2], irqSubPri);
    chk("flag", 1, flagReg[7+i]);
    settle();
    chk("flag clear", 0, flagReg[7+i]);
    @(posedge clk);
    enableReg <= '0;
  endtask
  task automatic t_masked();
    bit ok, seen;
    seen = 0;
    @(posedge clk);
    srcEvent[6] <= 1'b1;
    @(posedge clk);
    srcEvent[6] <= 1'b0;
    repeat (6) begin
      @(posedge clk);
      #1;
      seen = seen || (irqValid !== 1'b0);
    end
    chk("masked valid", 0, seen);
    chk("masked flag", 1, flagReg[13]);
    @(posedge clk);
    enableReg <= 32'h1 << 13;
    wait_hi(irqValid, ok);
    chk("late num", 45, irqNum);
    settle();
    @(posedge clk);
    enableReg <= '0;
  endtask
  task automatic t_persist();
    bit ok;
    @(posedge clk);
    enableReg <= 32'h1 << 22;
    srcEvent[15] <= 1'b1;
    wait_hi(irqAck, ok);
    wait_hi(irqValid, ok);
    chk("re-set", 1, ok);
    chk("re-set num", 54, irqNum);
    @(posedge clk);
    srcEvent[15] <= 1'b0;
    settle();
    @(posedge clk);
    enableReg <= '0;
  endtask
  task automatic t_nonpersist();
    bit ok;
    @(posedge clk);
    enableReg <= 32'h1 << 28;
    srcEvent[21] <= 1'b1;
    wait_hi(irqAck, ok);
    chk("dma ack", 1, ok);
    settle();
    chk("dma flag", 0, flagReg[28]);
    @(posedge clk);
    srcEvent[21] <= 1'b0;
    enableReg <= '0;
  endtask
  task automatic t_absent();
    bit seen;
    seen = 0;
    @(posedge clk);
    enableReg <= 32'h1 << 27;
    srcEvent[20] <= 1'b1;
    repeat (6) begin
      @(posedge clk);
      #1;
      seen = seen || (irqValid !== 1'b0);
    end
    chk("absent valid", 0, seen);
    chk("absent flag", 0, flagReg[27]);
    @(posedge clk);
    srcEvent[20] <= 1'b0;
    enableReg <= '0;
  endtask
  task automatic t_reset();
    bit ok;
    @(posedge clk);
    enableReg <= 32'h1 << 7;
    srcEvent[0] <= 1'b1;
    @(posedge clk);
    srcEvent[0] <= 1'b0;
    wait_hi(irqValid, ok);
    chk("pre-reset valid", 1, ok);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk("reset valid", 0, irqValid);
    chk("reset flags", 0, flagReg);
    @(posedge clk);
    rst <= 1'b0;
    enableReg <= '0;
    settle();
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Watchdog well beyond the few hundred cycles the tests take
  initial begin
    #20000;
    error_cnt++;
    finish_test();
  end
  initial begin
    rst = 1'b1;
    srcEvent = '0;
    enableReg = '0;
    // Nonzero priority in every lane; each priority and sub-priority pair distinct
    for (int k = 0; k < 12; k++) prio[8*k +: 8] = 8'((k % 7 + 1) * 4 + k % 4);
    {priorityReg10, priorityReg9, priorityReg8} = prio;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int n = 39; n <= 63; n++) if (n != 59) t_map(n);
    t_masked();
    t_persist();
    t_nonpersist();
    t_absent();
    t_reset();
    finish_test();
  end
endmodule
